// [rtl/asim_consts.svh]
// offsets, characters and timing figures shared by the ascii input module
// assumes inclusion by bare name from rtl files only
`ifndef ASIM_CONSTS_SVH
`define ASIM_CONSTS_SVH

`define ASIM_NPORT          4
`define ASIM_NPATH          4
`define ASIM_IMG_N          20
`define ASIM_QRY_LEN        16
`define ASIM_SIG_REG        16'h0001
`define ASIM_DATA_REG_MIN   16'h0002
`define ASIM_CHR_CR         8'h0d
`define ASIM_CHR_LF         8'h0a
`define ASIM_CHR_FF         8'h0c
`define ASIM_CHR_DIG0       8'h30
`define ASIM_CHR_DIG9       8'h39
`define ASIM_CHR_DIG1       8'h31
`define ASIM_CHR_DIG4       8'h34
`define ASIM_CLK_PERIOD_NS  100
`define ASIM_POLL_UNIT_MS   100
`define ASIM_POLL_UNIT_CYC  (`ASIM_POLL_UNIT_MS * 1000000 / `ASIM_CLK_PERIOD_NS)

`endif

// [rtl/asim_pkg.sv]
// types shared by the ascii input module and its bench
// assumes nothing beyond a systemverilog compiler
package asim_pkg;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } asim_char_t;

  typedef struct packed {
    logic       vld;
    logic [1:0] port;
    logic [3:0] idx;
    logic [7:0] data;
  } asim_qwr_t;

  typedef enum logic {
    LINK_IDLE,
    LINK_OPEN
  } asim_link_e;

endpackage : asim_pkg

// [rtl/asim_poll.sv]
// periodic query sender for one data port
// assumes config inputs are on clk_sys_i; gnt_i may stall the sender any cycle
`timescale 1ns/1ns
`include "asim_consts.svh"

module asim_poll #(
  parameter int UNIT_CYC = `ASIM_POLL_UNIT_CYC,
  parameter int QLEN     = `ASIM_QRY_LEN
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] rate_i,
  input  wire logic [4:0]  len_i,
  input  wire logic        wr_vld_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        gnt_i,
  output logic             req_o,
  output logic [7:0]       byte_o
);

  localparam int UW = $clog2(UNIT_CYC + 1);

  logic [7:0]    qry_mem [QLEN];
  logic [UW-1:0] unit_q;
  logic [15:0]   ivl_q;
  logic [3:0]    idx_q;
  logic          busy_q;
  logic          unit_tick;
  logic          fire;

  //////////////////////////////////////////////////////////////////////////////
  assign unit_tick = (rate_i != 16'h0000) && (unit_q == UW'(UNIT_CYC - 1));
  assign fire      = unit_tick && (ivl_q >= 16'(rate_i - 16'h0001));
  assign req_o     = busy_q;
  assign byte_o    = qry_mem[idx_q];

  always_ff @(posedge clk_sys_i) begin
    if (wr_vld_i) begin
      qry_mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unit_q <= '0;
    end else if (rate_i == 16'h0000 || unit_tick) begin
      unit_q <= '0;
    end else begin
      unit_q <= UW'(unit_q + 1'b1);
    end
  end

  // interval counted in whole poll units
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ivl_q <= 16'h0000;
    end else if (rate_i == 16'h0000 || fire) begin
      ivl_q <= 16'h0000;
    end else if (unit_tick) begin
      ivl_q <= 16'(ivl_q + 16'h0001);
    end
  end

  // a fire while a string is still going out is dropped, never queued
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      idx_q  <= 4'h0;
    end else if (rate_i == 16'h0000) begin
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      if (fire && len_i != 5'h00) begin
        busy_q <= 1'b1;
        idx_q  <= 4'h0;
      end
    end else if (gnt_i) begin
      if (5'(idx_q) == 5'(len_i - 5'h01)) begin
        busy_q <= 1'b0;
      end else begin
        idx_q <= 4'(idx_q + 4'h1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_POLL_OFF: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rate_i == 16'h0000 |=> !req_o) else $error("poll busy with zero rate");
  AST_POLL_FIRE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (fire && !busy_q && len_i != 5'h00) |=> req_o && idx_q == 4'h0) else $error("poll did not start");
  AST_POLL_STEP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (busy_q && gnt_i && 5'(idx_q) != 5'(len_i - 5'h01) && rate_i != 16'h0000 && $stable(rate_i))
    |=> idx_q == 4'($past(idx_q) + 4'h1)) else $error("query byte skipped");
  COV_POLL: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) busy_q && gnt_i);

endmodule : asim_poll

// [rtl/asim_top.sv]
// ascii input module core: per-port message capture, rack image, polling, relay
// assumes all character strobes and config come from logic on clk_sys_i
// Contract
// - each triggered port 1 message inverts signalling bit 1, even with unchanged data
// - integer editing writes the decimal value of a terminated message to its start register
// - receive indicator pulses once per character received on a data port
// - termination indicator goes on then off at each message end
// - pattern indicator goes on then off when a message matches a path pattern
// - rack sees signalling register at rack start, data registers following
// - local port numbering stays module-relative from register 1
// - nonzero poll rate sends the query string once per interval unaided
// - query string goes out byte for byte, control bytes included
// - poll rate zero stops periodic query transmission
// - first programming digit one to four with no link open selects the target port; other characters are ignored
// - the port-selection digit is consumed, never forwarded
// - open link forwards each programming character to the port, pulsing transmit indicator
// - carriage return, line feed or form feed closes the link
// - the closing character is still forwarded before the link closes
// - after closing, a digit one to four opens a new link
// - signalling bits 1-4 port 1, 5-8 port 2, 9-12 port 3, 13-16 port 4
`timescale 1ns/1ns
`include "asim_consts.svh"

module asim_top #(
  parameter int NPORT    = `ASIM_NPORT,
  parameter int IMG_N    = `ASIM_IMG_N,
  parameter int UNIT_CYC = `ASIM_POLL_UNIT_CYC
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  input  wire asim_pkg::asim_char_t [3:0]  rx_chr_i,
  input  wire asim_pkg::asim_char_t        prg_chr_i,
  input  wire logic [15:0]                 rack_base_i,
  input  wire logic [3:0][15:0]            start_reg_i,
  input  wire logic [3:0][15:0]            poll_rate_i,
  input  wire logic [3:0][4:0]             qry_len_i,
  input  wire asim_pkg::asim_qwr_t         qry_wr_i,
  input  wire logic [15:0]                 rack_rd_addr_i,
  input  wire logic [15:0]                 loc_rd_addr_i,
  output asim_pkg::asim_char_t [3:0]       tx_chr_o,
  output logic [15:0]                      rack_rd_data_o,
  output logic [15:0]                      loc_rd_data_o,
  output logic [3:0]                       rx_led_o,
  output logic [3:0]                       term_led_o,
  output logic [3:0]                       pat_led_o,
  output logic [3:0]                       tx_led_o,
  output logic                             link_open_o,
  output logic [1:0]                       link_port_o
);

  logic [15:0]          acc_q  [NPORT];
  logic [3:0]           cnt_q  [NPORT];
  logic [NPORT-1:0]     done_q;
  logic [15:0]          val_q  [NPORT];
  logic [15:0]          sig_q;
  logic [15:0]          img_q  [2:IMG_N];
  asim_pkg::asim_link_e link_q;
  logic [1:0]           sel_q;
  logic [NPORT-1:0]     relay_now;
  logic [NPORT-1:0]     poll_req;
  logic [NPORT-1:0]     poll_gnt;
  logic [7:0]           poll_byte [NPORT];
  logic                 prg_digit;
  logic                 prg_end;
  logic [15:0]          rack_off;

  default clocking cb_chk @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= `ASIM_CHR_DIG0) && (c <= `ASIM_CHR_DIG9);
  endfunction : is_digit

  function automatic logic [15:0] img_read(input logic [15:0] idx,
                                           input logic [15:0] sig,
                                           input logic [15:0] img [2:IMG_N]);
    img_read = 16'h0000;
    if (idx == `ASIM_SIG_REG) begin
      img_read = sig;
    end else if (idx >= `ASIM_DATA_REG_MIN && idx <= 16'(IMG_N)) begin
      img_read = img[idx];
    end
  endfunction : img_read

  //////////////////////////////////////////////////////////////////////////////
  // message capture; terminator is carriage return, empty messages are dropped

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_q <= '0;
      for (int p = 0; p < NPORT; p++) begin
        acc_q[p] <= 16'h0000;
        cnt_q[p] <= 4'h0;
        val_q[p] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        done_q[p] <= 1'b0;
        if (rx_chr_i[p].vld) begin
          if (rx_chr_i[p].data == `ASIM_CHR_CR) begin
            done_q[p] <= (cnt_q[p] != 4'h0);
            val_q[p]  <= acc_q[p];
            acc_q[p]  <= 16'h0000;
            cnt_q[p]  <= 4'h0;
          end else begin
            if (cnt_q[p] != 4'hf) begin
              cnt_q[p] <= 4'(cnt_q[p] + 4'h1);
            end
            // value wraps at 16 bits; non-digits are skipped by the editor
            if (is_digit(rx_chr_i[p].data)) begin
              acc_q[p] <= 16'(acc_q[p] * 16'd10 + 16'(rx_chr_i[p].data - `ASIM_CHR_DIG0));
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indicators: termination and pattern are one-cycle pulses; receive follows the strobe

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_led_o   <= 4'h0;
      term_led_o <= 4'h0;
      pat_led_o  <= 4'h0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        rx_led_o[p]   <= rx_chr_i[p].vld;
        term_led_o[p] <= done_q[p];
        pat_led_o[p]  <= done_q[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // signalling register and image; only path 1 of each port, wildcard pattern

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sig_q <= 16'h0000;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (done_q[p]) begin
          sig_q[p * `ASIM_NPATH] <= !sig_q[p * `ASIM_NPATH];
        end
      end
    end
  end

  // two ports aimed at one register: the higher port wins
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int r = 2; r <= IMG_N; r++) begin
        img_q[r] <= 16'h0000;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (done_q[p] && start_reg_i[p] >= `ASIM_DATA_REG_MIN && start_reg_i[p] <= 16'(IMG_N)) begin
          img_q[start_reg_i[p]] <= val_q[p];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register reads: rack view is offset by rack base, local view is not

  assign rack_off = 16'(rack_rd_addr_i - rack_base_i);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rack_rd_data_o <= 16'h0000;
      loc_rd_data_o  <= 16'h0000;
    end else begin
      rack_rd_data_o <= img_read(16'(rack_off + `ASIM_SIG_REG), sig_q, img_q);
      if (rack_off >= 16'(IMG_N)) begin
        rack_rd_data_o <= 16'h0000;
      end
      loc_rd_data_o <= img_read(loc_rd_addr_i, sig_q, img_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // programming-port relay

  assign prg_digit = (prg_chr_i.data >= `ASIM_CHR_DIG1) && (prg_chr_i.data <= `ASIM_CHR_DIG4);
  assign prg_end   = (prg_chr_i.data == `ASIM_CHR_CR) || (prg_chr_i.data == `ASIM_CHR_LF)
                  || (prg_chr_i.data == `ASIM_CHR_FF);
  assign link_open_o = link_q;
  assign link_port_o = sel_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_q <= asim_pkg::LINK_IDLE;
      sel_q  <= 2'h0;
    end else begin
      case (link_q)
        asim_pkg::LINK_IDLE: begin
          if (prg_chr_i.vld && prg_digit) begin
            link_q <= asim_pkg::LINK_OPEN;
            sel_q  <= 2'(prg_chr_i.data[1:0] - 2'h1);
          end
        end
        asim_pkg::LINK_OPEN: begin
          if (prg_chr_i.vld && prg_end) begin
            link_q <= asim_pkg::LINK_IDLE;
          end
        end
        default: begin
          link_q <= asim_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      relay_now[p] = link_open_o && prg_chr_i.vld && (sel_q == 2'(p));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit side: relay takes the port, poll waits behind it

  assign poll_gnt = poll_req & ~relay_now;

  for (genvar g = 0; g < NPORT; g++) begin : g_poll
    asim_poll #(
      .UNIT_CYC (UNIT_CYC),
      .QLEN     (`ASIM_QRY_LEN)
    ) u_poll (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .rate_i    (poll_rate_i[g]),
      .len_i     (qry_len_i[g]),
      .wr_vld_i  (qry_wr_i.vld && qry_wr_i.port == 2'(g)),
      .wr_idx_i  (qry_wr_i.idx),
      .wr_data_i (qry_wr_i.data),
      .gnt_i     (poll_gnt[g]),
      .req_o     (poll_req[g]),
      .byte_o    (poll_byte[g])
    );
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_chr_o <= '0;
      tx_led_o <= 4'h0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (relay_now[p]) begin
          tx_chr_o[p] <= '{vld: 1'b1, data: prg_chr_i.data};
        end else if (poll_req[p]) begin
          tx_chr_o[p] <= '{vld: 1'b1, data: poll_byte[p]};
        end else begin
          tx_chr_o[p] <= '{vld: 1'b0, data: 8'h00};
        end
        tx_led_o[p] <= relay_now[p] || poll_req[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_TOGGLE: assert property (
    done_q[0] |=> sig_q[0] != $past(sig_q[0]))
    else $error("port 1 trigger bit not inverted");
  AST_IMG_WR: assert property (
    (done_q[0] && start_reg_i[0] == 16'h0002 && done_q[3:1] == 3'h0) |=> img_q[2] == $past(val_q[0]))
    else $error("value missing in start register");
  AST_RX_LED: assert property (
    rx_chr_i[0].vld |=> rx_led_o[0] ##1 (rx_led_o[0] == $past(rx_chr_i[0].vld)))
    else $error("receive indicator wrong");
  AST_TERM: assert property (
    (rx_chr_i[1].vld && rx_chr_i[1].data == 8'h0d && cnt_q[1] != 4'h0) |=> ##1 term_led_o[1] ##1 !term_led_o[1])
    else $error("termination indicator not on then off");
  AST_PAT: assert property (
    pat_led_o[2] |-> sig_q[8] != $past(sig_q[8]))
    else $error("pattern indicator without toggle");
  AST_RACK: assert property (
    (rack_rd_addr_i == 16'(rack_base_i + 16'h0001) && start_reg_i[0] == 16'h0002 && !done_q[0]
     && $stable(rack_base_i)) |=> rack_rd_data_o == img_q[2])
    else $error("rack view offset wrong");
  AST_RACK_OUT: assert property (
    rack_off >= 16'(IMG_N) |=> rack_rd_data_o == 16'h0000)
    else $error("rack read outside the image not zero");
  AST_LOCAL: assert property (
    (loc_rd_addr_i == 16'h0001 && done_q == '0) |=> loc_rd_data_o == sig_q)
    else $error("local view not module-relative");
  AST_LOCAL_OUT: assert property (
    loc_rd_addr_i == 16'h0000 |=> loc_rd_data_o == 16'h0000)
    else $error("local register 0 not empty");
  AST_SELECT: assert property (
    (!link_open_o && prg_chr_i.vld && prg_digit) |=> link_open_o
    && link_port_o == 2'($past(prg_chr_i.data[1:0]) - 2'h1)
    && (!tx_chr_o[link_port_o].vld || $past(poll_req) != '0))
    else $error("port select wrong or forwarded");
  AST_FWD: assert property (
    (link_open_o && prg_chr_i.vld && sel_q == 2'h0)
    |=> tx_chr_o[0].vld && tx_chr_o[0].data == $past(prg_chr_i.data) && tx_led_o[0])
    else $error("relay character not forwarded");
  AST_CLOSE: assert property (
    (link_open_o && prg_chr_i.vld && prg_end) |=> !link_open_o)
    else $error("link did not close");
  AST_HOLD: assert property (
    (link_open_o && !(prg_chr_i.vld && prg_end)) |=> link_open_o && link_port_o == $past(link_port_o))
    else $error("open link dropped or moved");
  AST_IGNORE: assert property (
    (!link_open_o && prg_chr_i.vld && !prg_digit) |=> !link_open_o && link_port_o == $past(link_port_o))
    else $error("non-digit opened or moved a link");

  // path 2-4 bits stay clear: only path 1 of each port is modelled
  for (genvar g = 0; g < NPORT; g++) begin : g_chk
    AST_SIG_BIT: assert property (
      (sig_q[g * `ASIM_NPATH] ^ $past(sig_q[g * `ASIM_NPATH])) == $past(done_q[g]))
      else $error("signalling bit toggle wrong");
    AST_SIG_SPARE: assert property (
      sig_q[g * `ASIM_NPATH + 1 +: 3] == 3'h0)
      else $error("unused path bit set");
    AST_TERM_ON: assert property (
      done_q[g] |=> term_led_o[g] && pat_led_o[g] ##1 !term_led_o[g] && !pat_led_o[g])
      else $error("indicators not on then off");
    AST_LED_QUIET: assert property (
      !done_q[g] |=> !term_led_o[g] && !pat_led_o[g])
      else $error("indicator pulse without message");
    AST_RX_EACH: assert property (
      rx_led_o[g] == $past(rx_chr_i[g].vld))
      else $error("receive pulse count wrong");
    AST_TX_LED: assert property (
      tx_led_o[g] == tx_chr_o[g].vld)
      else $error("transmit indicator out of step");
    AST_QUIET_TX: assert property (
      (!link_open_o && !poll_req[g]) |=> !tx_chr_o[g].vld)
      else $error("character sent with no link and no poll");
    AST_MSG_CLEAR: assert property (
      (rx_chr_i[g].vld && rx_chr_i[g].data == `ASIM_CHR_CR) |=> acc_q[g] == 16'h0000 && cnt_q[g] == 4'h0)
      else $error("message buffer not cleared");
  end : g_chk

  COV_TOGGLE: cover property (done_q[0] ##[1:200] done_q[0]);
  COV_OPEN: cover property (!link_open_o ##1 link_open_o);
  COV_CLOSE: cover property (link_open_o ##1 !link_open_o);
  COV_CLASH: cover property ((poll_req & relay_now) != '0);

endmodule : asim_top

// [verif/asim_dev_model.sv]
// far-side model: serial devices on the four data ports and the programming terminal
// assumes asim_pkg is compiled first; drives character strobes on clk_sys_i rising edges
`timescale 1ns/1ns

module asim_dev_model (
  input  wire logic                  clk_sys_i,
  output asim_pkg::asim_char_t [3:0] rx_o,
  output asim_pkg::asim_char_t       prg_o
);
  // slot 4 is the programming terminal
  asim_pkg::asim_char_t [4:0] line_q = '0;

  assign rx_o  = line_q[3:0];
  assign prg_o = line_q[4];

  ////////////////////////////////////////////////////////////////////////////////
  // characters go out back to back; data is inverted once the strobe drops
  // so a stale byte is never mistaken for a fresh one
  task automatic send(input int p, input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_sys_i);
      line_q[p] <= {1'b1, s[i]};
    end
    @(posedge clk_sys_i);
    line_q[p] <= {1'b0, ~s[s.len()-1]};
  endtask : send

endmodule : asim_dev_model

// [verif/ascii_serial_input_module_test.sv]
// self-checking bench for asim_top with a short poll unit
// assumes asim_pkg, asim_top and asim_dev_model are compiled first
`timescale 1ns/1ns

module ascii_serial_input_module_test;
  logic                       clk_sys_i;
  logic                       sys_rst_i;
  asim_pkg::asim_char_t [3:0] rx_chr_i;
  asim_pkg::asim_char_t [3:0] tx_chr_o;
  asim_pkg::asim_char_t       prg_chr_i;
  asim_pkg::asim_qwr_t        qry_wr_i;
  logic [15:0]                rack_base_i;
  logic [15:0]                rack_rd_addr_i;
  logic [15:0]                loc_rd_addr_i;
  logic [15:0]                rack_rd_data_o;
  logic [15:0]                loc_rd_data_o;
  logic [3:0][15:0]           start_reg_i;
  logic [3:0][15:0]           poll_rate_i;
  logic [3:0][4:0]            qry_len_i;
  logic [3:0]                 rx_led_o;
  logic [3:0]                 term_led_o;
  logic [3:0]                 pat_led_o;
  logic [3:0]                 tx_led_o;
  logic                       link_open_o;
  logic [1:0]                 link_port_o;
  logic [15:0]                sig_exp;
  logic [7:0]                 txq [4][$];
  int                         cnt_rx [4];
  int                         cnt_term [4];
  int                         cnt_pat [4];
  int                         cnt_tx [4];
  int                         errors;
  int                         checks;
  int                         cyc;

  asim_top #(.UNIT_CYC(4)) u_asim_top (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rx_chr_i(rx_chr_i), .prg_chr_i(prg_chr_i),
    .rack_base_i(rack_base_i), .start_reg_i(start_reg_i), .poll_rate_i(poll_rate_i),
    .qry_len_i(qry_len_i), .qry_wr_i(qry_wr_i), .rack_rd_addr_i(rack_rd_addr_i),
    .loc_rd_addr_i(loc_rd_addr_i), .tx_chr_o(tx_chr_o), .rack_rd_data_o(rack_rd_data_o),
    .loc_rd_data_o(loc_rd_data_o), .rx_led_o(rx_led_o), .term_led_o(term_led_o),
    .pat_led_o(pat_led_o), .tx_led_o(tx_led_o), .link_open_o(link_open_o), .link_port_o(link_port_o)
  );

  asim_dev_model u_dev (.clk_sys_i(clk_sys_i), .rx_o(rx_chr_i), .prg_o(prg_chr_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: pulses are sampled on the edge after they launch, so no race with nba
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      finish_test();
    end
    for (int p = 0; p < 4; p++) begin
      if (rx_led_o[p] === 1'b1) cnt_rx[p]++;
      if (term_led_o[p] === 1'b1) cnt_term[p]++;
      if (pat_led_o[p] === 1'b1) cnt_pat[p]++;
      if (tx_led_o[p] === 1'b1) cnt_tx[p]++;
      if (tx_chr_o[p].vld === 1'b1) txq[p].push_back(tx_chr_o[p].data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc

  task automatic clear_mon;
    for (int p = 0; p < 4; p++) begin
      cnt_rx[p] = 0;
      cnt_term[p] = 0;
      cnt_pat[p] = 0;
      cnt_tx[p] = 0;
      txq[p].delete();
    end
  endtask : clear_mon

  // read data is registered: one edge after the address is taken
  task automatic rd(input logic rack, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    if (rack) rack_rd_addr_i <= a;
    else loc_rd_addr_i <= a;
    @(posedge clk_sys_i);
    #1;
    check(rack ? rack_rd_data_o : loc_rd_data_o, exp, rack ? "rack read" : "local read");
  endtask : rd

  task automatic chk_q(input int p, input string s);
    check(16'(txq[p].size()), 16'(s.len()), "tx count");
    for (int i = 0; i < s.len() && i < txq[p].size(); i++)
      check({8'h00, txq[p][i]}, {8'h00, s[i]}, "tx byte");
  endtask : chk_q

  ////////////////////////////////////////////////////////////////////////////////
  // same value twice must still toggle the flag
  task automatic t_input;
    string s [3] = '{"123\r", "456\r", "456\r"};
    logic [15:0] v [3] = '{16'h007b, 16'h01c8, 16'h01c8};
    for (int k = 0; k < 3; k++) begin
      clear_mon();
      u_dev.send(0, s[k]);
      wait_cyc(3);
      sig_exp[0] = ~sig_exp[0];
      check(16'(cnt_rx[0]), 16'h0004, "rx pulses");
      check(16'(cnt_term[0]), 16'h0001, "term pulses");
      check(16'(cnt_pat[0]), 16'h0001, "pattern pulses");
      rd(1'b0, 16'h0001, sig_exp);
      rd(1'b0, 16'h0002, v[k]);
    end
  endtask : t_input

  task automatic t_ports;
    for (int p = 1; p < 4; p++) begin
      u_dev.send(p, $sformatf("%0d\r", 100 + p));
      wait_cyc(3);
      sig_exp[p*4] = ~sig_exp[p*4];
      rd(1'b0, 16'h0001, sig_exp);
      rd(1'b0, 16'(p + 3), 16'(100 + p));
    end
  endtask : t_ports

  task automatic t_rack;
    rd(1'b1, 16'h0029, sig_exp);
    rd(1'b1, 16'h002a, 16'h01c8);
    rd(1'b1, 16'h002c, 16'h0065);
    rd(1'b1, 16'h0028, 16'h0000);
    rd(1'b0, 16'h0002, 16'h01c8);
  endtask : t_rack

  task automatic t_relay;
    clear_mon();
    u_dev.send(4, "x");
    wait_cyc(2);
    check(16'(link_open_o), 16'h0000, "link after non-digit");
    u_dev.send(4, "1");
    wait_cyc(1);
    check(16'(link_open_o), 16'h0001, "link open");
    check(16'(link_port_o), 16'h0000, "link port");
    u_dev.send(4, "AB\r");
    wait_cyc(2);
    chk_q(0, "AB\r");
    check(16'(cnt_tx[0]), 16'h0003, "tx pulses");
    check(16'(link_open_o), 16'h0000, "link after cr");
    u_dev.send(4, "2Q\n");
    wait_cyc(2);
    chk_q(1, "Q\n");
    u_dev.send(4, "4Z\f");
    wait_cyc(2);
    chk_q(3, "Z\f");
    check(16'(link_port_o), 16'h0003, "link port four");
    check(16'(link_open_o), 16'h0000, "link after ff");
  endtask : t_relay

  // interval of 5 units of 4 cycles: exactly three strings land in 70 cycles
  task automatic t_poll;
    string q = "Hello\r\n";
    for (int i = 0; i < q.len(); i++) begin
      @(posedge clk_sys_i);
      qry_wr_i <= '{1'b1, 2'h3, 4'(i), q[i]};
    end
    @(posedge clk_sys_i);
    qry_wr_i <= '0;
    clear_mon();
    qry_len_i[3] <= 5'h07;
    poll_rate_i[3] <= 16'h0005;
    wait_cyc(70);
    chk_q(3, "Hello\r\nHello\r\nHello\r\n");
    @(posedge clk_sys_i);
    poll_rate_i[3] <= 16'h0000;
    wait_cyc(4);
    clear_mon();
    wait_cyc(60);
    check(16'(txq[3].size()), 16'h0000, "poll after disable");
  endtask : t_poll

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b1;
    rack_base_i = 16'h0029;
    start_reg_i = {16'h0006, 16'h0005, 16'h0004, 16'h0002};
    poll_rate_i = '0;
    qry_len_i = '0;
    qry_wr_i = '0;
    rack_rd_addr_i = 16'h0000;
    loc_rd_addr_i = 16'h0000;
    sig_exp = 16'h0000;
    errors = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    wait_cyc(1);
    check(16'(link_open_o), 16'h0000, "link after reset");
    rd(1'b0, 16'h0001, 16'h0000);
    t_input();
    t_ports();
    t_rack();
    t_relay();
    t_poll();
    finish_test();
  end

endmodule : ascii_serial_input_module_test
